/* rtl/dax_pkg.sv */
// Constants for the DAC auxiliary control logic
package dax_pkg;
   // Clock and busy timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int AB_BUSY_NS = 600;
   localparam int AB_BUSY_CYC = (AB_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CNT_W = 7;
   // Word layout
   localparam int DATA_W = 16;
   localparam int CH_N = 16;
   localparam int CH_W = 4;
   localparam int CODE_W = 6;
   // Mode field of a command
   localparam logic [1:0] MODE_SPECIAL = 2'h0;
   localparam logic [1:0] MODE_LEVEL = 2'h1;
   localparam logic [1:0] MODE_OFFSET = 2'h2;
   localparam logic [1:0] MODE_GAIN = 2'h3;
   // Special-function codes
   localparam logic [5:0] SF_CONTROL = 6'h01;
   localparam logic [5:0] SF_READBACK = 6'h05;
   localparam logic [5:0] SF_MONITOR = 6'h0c;
   localparam logic [5:0] SF_GPIO = 6'h0d;
   localparam logic [5:0] SF_AB_SEL0 = 6'h0e;
   localparam logic [5:0] SF_AB_SEL1 = 6'h0f;
   // Control register fields
   localparam int CTL_PD = 0;
   localparam int CTL_TEMP_EN = 1;
   localparam int CTL_AB = 2;
   localparam int CTL_TEMP_FLAG = 4;
   localparam int CTL_W = 5;
   // Monitor register fields
   localparam int MON_EN = 5;
   localparam int MON_AUX = 4;
   localparam int MON_W = 6;
   // GPIO register fields
   localparam int GPIO_DIR = 1;
   localparam int GPIO_LVL = 0;
   localparam int GPIO_W = 2;
   // A/B select width per register
   localparam int AB_W = 8;
   // Reset values and arithmetic
   localparam logic [15:0] LEVEL_RST = 16'h8000;
   localparam logic [15:0] OFFSET_RST = 16'h8000;
   localparam logic [15:0] GAIN_RST = 16'hffff;
   localparam logic [15:0] SIGN_MASK = 16'h8000;
   localparam logic [17:0] OFFSET_BIAS = 18'h08000;
   localparam logic [17:0] CODE_MAX = 18'h0ffff;
endpackage

/* rtl/dax_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module dax_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Asynchronous input and synchronised level
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_d;

   // Change counts only once stages two and three agree
   assign out_d = (s2_q == s3_q) ? s3_q : sync_out;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         sync_out <= RST;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         sync_out <= out_d;
      end
   end
endmodule // dax_sync

/* rtl/dax_aux_ctrl.sv */
// Auxiliary control logic of a 16-channel DAC
// Function
// - Format pin low: level/offset data straight binary; high: twos complement.
// - Gain and control words always decoded as straight binary.
// - Monitor enable bit gates the monitor output regardless of select bits.
// - Source bit 0 picks channel by low four bits; 1 picks aux input.
// - Disabled monitor output is released to high impedance.
// - GPIO direction bit 1 makes pin an output following level bit.
// - Writing zero to both GPIO bits makes the pin an input.
// - GPIO register is selected by special-function code 001101.
// - GPIO readback returns present pin level in the least significant bit.
// - Control bit 0 powers down channels, outputs go to signal ground.
// - Power-down keeps registers; clearing it restores previous outputs.
// - Thermal enable plus over-temperature acts as power-down.
// - Entering thermal shutdown sets control bit 4 as readable flag.
// - Thermal shutdown persists until host clears control bit 1; an over-temperature trip in the same cycle keeps the flag set.
// - Each channel holds A and B calculated values, recomputed on writes.
// - Each A/B select register steers eight channels without recalculation.
// - Load strobe fills each DAC register from A or B per select.
// - Any A/B select write asserts busy for about 600 ns.
`timescale 1ns/10ps
module dax_aux_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Decoded serial command word
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_mode,
   input wire logic [5:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   // Readback answer
   output logic rd_valid,
   output logic [15:0] rd_data,
   // Device pins
   input wire logic data_format_select,
   input wire logic load_strobe_n,
   input wire logic over_temp,
   output logic busy_n,
   // General-purpose pin
   input wire logic gpio_i,
   output logic gpio_o,
   output logic gpio_oe,
   // Monitor multiplexer controls
   output logic monitor_output_oe,
   output logic monitor_source_type,
   output logic [3:0] monitor_channel_sel,
   // Channel outputs
   output logic channel_to_ground,
   output logic [255:0] dac_code
);
   localparam int BUSY_CYC = dax_pkg::AB_BUSY_CYC;
   localparam logic [6:0] BUSY_LOAD = 7'(dax_pkg::AB_BUSY_CYC);

   // Gain-scaled level plus offset, clamped to code range
   function automatic logic [15:0] calc_level(input logic [15:0] x, input logic [15:0] m,
                                               input logic [15:0] c);
      logic [32:0] prod;
      logic [17:0] sum;
      prod = {17'h00000, x} * {1'b0, m};
      prod = prod + {17'h00000, x};
      sum = {2'h0, prod[31:16]} + {2'h0, c};
      if (sum < dax_pkg::OFFSET_BIAS) begin
         calc_level = 16'h0000;
      end else if (sum - dax_pkg::OFFSET_BIAS > dax_pkg::CODE_MAX) begin
         calc_level = 16'hffff;
      end else begin
         calc_level = 16'(sum - dax_pkg::OFFSET_BIAS);
      end
   endfunction

   // Synchronised pins
   logic fmt_s;
   logic load_s;
   logic hot_s;
   logic gpio_s;
   dax_sync #(.W(1), .RST(1'b0)) u_sync_fmt (
      .mclk(mclk), .resetn(resetn), .async_in(data_format_select), .sync_out(fmt_s));
   dax_sync #(.W(1), .RST(1'b1)) u_sync_load (
      .mclk(mclk), .resetn(resetn), .async_in(load_strobe_n), .sync_out(load_s));
   dax_sync #(.W(1), .RST(1'b0)) u_sync_hot (
      .mclk(mclk), .resetn(resetn), .async_in(over_temp), .sync_out(hot_s));
   dax_sync #(.W(1), .RST(1'b0)) u_sync_gpio (
      .mclk(mclk), .resetn(resetn), .async_in(gpio_i), .sync_out(gpio_s));

   // Register state
   logic [15:0] xa_q [dax_pkg::CH_N];
   logic [15:0] xb_q [dax_pkg::CH_N];
   logic [15:0] off_q [dax_pkg::CH_N];
   logic [15:0] gain_q [dax_pkg::CH_N];
   logic [15:0] ca_q [dax_pkg::CH_N];
   logic [15:0] cb_q [dax_pkg::CH_N];
   logic [15:0] dac_q [dax_pkg::CH_N];
   logic [4:0] ctl_q;
   logic [4:0] ctl_d;
   logic [5:0] mon_q;
   logic [1:0] gpio_q;
   logic [1:0] gpio_d;
   logic [15:0] absel_q;
   logic [6:0] busy_cnt_q;
   logic [6:0] busy_cnt_d;
   logic load_prev_q;
   logic pend_q;
   logic rd_valid_q;
   logic [15:0] rd_data_q;
   logic [15:0] rd_data_d;

   // Command decode
   wire sf_we = cmd_valid && (cmd_mode == dax_pkg::MODE_SPECIAL);
   wire ctl_we = sf_we && (cmd_addr == dax_pkg::SF_CONTROL);
   wire mon_we = sf_we && (cmd_addr == dax_pkg::SF_MONITOR);
   wire gpio_we = sf_we && (cmd_addr == dax_pkg::SF_GPIO);
   wire ab0_we = sf_we && (cmd_addr == dax_pkg::SF_AB_SEL0);
   wire ab1_we = sf_we && (cmd_addr == dax_pkg::SF_AB_SEL1);
   wire ab_we = ab0_we || ab1_we;
   wire rb_req = sf_we && (cmd_addr == dax_pkg::SF_READBACK);
   wire [5:0] rb_code = cmd_data[5:0];
   wire x_we = cmd_valid && (cmd_mode == dax_pkg::MODE_LEVEL);
   wire c_we = cmd_valid && (cmd_mode == dax_pkg::MODE_OFFSET);
   wire m_we = cmd_valid && (cmd_mode == dax_pkg::MODE_GAIN);
   wire [3:0] ch = cmd_addr[3:0];
   wire to_b = ctl_q[dax_pkg::CTL_AB];

   // Level and offset data follow the format pin; gain does not
   wire [15:0] fmt_data = fmt_s ? (cmd_data ^ dax_pkg::SIGN_MASK) : cmd_data;
   wire [15:0] new_xa = (x_we && !to_b) ? fmt_data : xa_q[ch];
   wire [15:0] new_xb = (x_we && to_b) ? fmt_data : xb_q[ch];
   wire [15:0] new_c = c_we ? fmt_data : off_q[ch];
   wire [15:0] new_m = m_we ? cmd_data : gain_q[ch];
   wire data_we = x_we || c_we || m_we;
   wire [15:0] calc_a = calc_level(new_xa, new_m, new_c);
   wire [15:0] calc_b = calc_level(new_xb, new_m, new_c);

   // Thermal shutdown: set beats the clear
   wire temp_set = ctl_q[dax_pkg::CTL_TEMP_EN] && hot_s;
   always_comb begin
      ctl_d = ctl_q;
      if (ctl_we) begin
         ctl_d[dax_pkg::CTL_PD] = cmd_data[dax_pkg::CTL_PD];
         ctl_d[dax_pkg::CTL_TEMP_EN] = cmd_data[dax_pkg::CTL_TEMP_EN];
         ctl_d[dax_pkg::CTL_AB] = cmd_data[dax_pkg::CTL_AB];
         if (!cmd_data[dax_pkg::CTL_TEMP_EN]) begin
            ctl_d[dax_pkg::CTL_TEMP_FLAG] = 1'b0;
         end
      end
      if (temp_set) begin
         ctl_d[dax_pkg::CTL_TEMP_FLAG] = 1'b1;
      end
   end

   // GPIO: output only while direction bit set
   always_comb begin
      gpio_d = gpio_q;
      if (gpio_we) begin
         gpio_d = cmd_data[1:0];
         if (!cmd_data[dax_pkg::GPIO_DIR]) begin
            gpio_d = 2'h0;
         end
      end
   end

   // Busy count restarts on every A/B select write
   always_comb begin
      busy_cnt_d = busy_cnt_q;
      if (ab_we) begin
         busy_cnt_d = BUSY_LOAD;
      end else if (busy_cnt_q != 7'h00) begin
         busy_cnt_d = busy_cnt_q - 7'h01;
      end
   end
   wire busy = (busy_cnt_q != 7'h00);

   // Load strobe falling edge, held while busy
   wire load_evt = load_prev_q && !load_s;
   wire load_apply = (load_evt || pend_q) && !busy;

   // Readback selection
   always_comb begin
      unique case (rb_code)
         dax_pkg::SF_CONTROL: rd_data_d = {11'h000, ctl_q};
         dax_pkg::SF_MONITOR: rd_data_d = {10'h000, mon_q};
         dax_pkg::SF_GPIO: rd_data_d = {14'h0000, gpio_q[dax_pkg::GPIO_DIR], gpio_s};
         dax_pkg::SF_AB_SEL0: rd_data_d = {8'h00, absel_q[7:0]};
         dax_pkg::SF_AB_SEL1: rd_data_d = {8'h00, absel_q[15:8]};
         default: rd_data_d = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctl_q <= 5'h00;
         mon_q <= 6'h00;
         gpio_q <= 2'h0;
         absel_q <= 16'h0000;
         busy_cnt_q <= 7'h00;
         load_prev_q <= 1'b1;
         pend_q <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end else begin
         ctl_q <= ctl_d;
         gpio_q <= gpio_d;
         busy_cnt_q <= busy_cnt_d;
         load_prev_q <= load_s;
         pend_q <= (pend_q || load_evt) && busy;
         rd_valid_q <= rb_req;
         rd_data_q <= rb_req ? rd_data_d : rd_data_q;
         if (mon_we) begin
            mon_q <= cmd_data[5:0];
         end
         if (ab0_we) begin
            absel_q[7:0] <= cmd_data[7:0];
         end
         if (ab1_we) begin
            absel_q[15:8] <= cmd_data[7:0];
         end
      end
   end

   // Channel storage; power-down never touches it
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int i = 0; i < dax_pkg::CH_N; i++) begin
            xa_q[i] <= dax_pkg::LEVEL_RST;
            xb_q[i] <= dax_pkg::LEVEL_RST;
            off_q[i] <= dax_pkg::OFFSET_RST;
            gain_q[i] <= dax_pkg::GAIN_RST;
            ca_q[i] <= dax_pkg::LEVEL_RST;
            cb_q[i] <= dax_pkg::LEVEL_RST;
            dac_q[i] <= dax_pkg::LEVEL_RST;
         end
      end else begin
         if (data_we) begin
            xa_q[ch] <= new_xa;
            xb_q[ch] <= new_xb;
            off_q[ch] <= new_c;
            gain_q[ch] <= new_m;
            ca_q[ch] <= calc_a;
            cb_q[ch] <= calc_b;
         end
         if (load_apply) begin
            for (int i = 0; i < dax_pkg::CH_N; i++) begin
               dac_q[i] <= absel_q[i] ? cb_q[i] : ca_q[i];
            end
         end
      end
   end

   // Outputs
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign busy_n = !busy;
   assign gpio_oe = gpio_q[dax_pkg::GPIO_DIR];
   assign gpio_o = gpio_q[dax_pkg::GPIO_LVL];
   assign monitor_output_oe = mon_q[dax_pkg::MON_EN];
   assign monitor_source_type = mon_q[dax_pkg::MON_AUX];
   assign monitor_channel_sel = mon_q[3:0];
   assign channel_to_ground = ctl_q[dax_pkg::CTL_PD] || ctl_q[dax_pkg::CTL_TEMP_FLAG];
   for (genvar g = 0; g < dax_pkg::CH_N; g++) begin : g_out
      assign dac_code[g*16 +: 16] = dac_q[g];
   end

   // Checks
   wire [15:0] next_dac0 = absel_q[0] ? cb_q[0] : ca_q[0];
   wire gpio_rb = rb_req && (rb_code == dax_pkg::SF_GPIO);

   property p_fmt_level;
      @(posedge mclk) disable iff (!resetn)
      (x_we && !to_b) |=> (xa_q[$past(ch)] == $past(fmt_data));
   endproperty
   a_fmt_level: assert property (p_fmt_level) else $error("level not format-converted");

   property p_gain_straight;
      @(posedge mclk) disable iff (!resetn)
      m_we |=> (gain_q[$past(ch)] == $past(cmd_data));
   endproperty
   a_gain_straight: assert property (p_gain_straight) else $error("gain altered by format");

   property p_mon_off;
      @(posedge mclk) disable iff (!resetn)
      (mon_we && !cmd_data[dax_pkg::MON_EN]) |=> !monitor_output_oe;
   endproperty
   a_mon_off: assert property (p_mon_off) else $error("monitor not released");

   property p_gpio_out;
      @(posedge mclk) disable iff (!resetn)
      (gpio_we && cmd_data[dax_pkg::GPIO_DIR]) |=> (gpio_oe && (gpio_o == $past(cmd_data[0])));
   endproperty
   a_gpio_out: assert property (p_gpio_out) else $error("gpio not driven as written");

   property p_gpio_in;
      @(posedge mclk) disable iff (!resetn)
      (gpio_we && (cmd_data[1:0] == 2'h0)) |=> !gpio_oe;
   endproperty
   a_gpio_in: assert property (p_gpio_in) else $error("gpio still driven");

   property p_gpio_rb;
      @(posedge mclk) disable iff (!resetn)
      gpio_rb |=> (rd_valid && (rd_data[0] == $past(gpio_s)));
   endproperty
   a_gpio_rb: assert property (p_gpio_rb) else $error("gpio readback wrong");

   property p_pd;
      @(posedge mclk) disable iff (!resetn)
      (ctl_we && cmd_data[dax_pkg::CTL_PD]) |=> channel_to_ground;
   endproperty
   a_pd: assert property (p_pd) else $error("power-down not applied");

   property p_temp_trip;
      @(posedge mclk) disable iff (!resetn)
      temp_set |=> (ctl_q[dax_pkg::CTL_TEMP_FLAG] && channel_to_ground);
   endproperty
   a_temp_trip: assert property (p_temp_trip) else $error("thermal shutdown missed");

   property p_temp_hold;
      @(posedge mclk) disable iff (!resetn)
      (ctl_q[dax_pkg::CTL_TEMP_FLAG] && !ctl_we) |=> ctl_q[dax_pkg::CTL_TEMP_FLAG];
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("thermal shutdown dropped");

   sequence s_busy_low;
      (!busy_n)[*8];
   endsequence
   property p_ab_busy;
      @(posedge mclk) disable iff (!resetn)
      ab_we |=> s_busy_low ##[1:BUSY_CYC] (busy_n || ab_we);
   endproperty
   a_ab_busy: assert property (p_ab_busy) else $error("busy after select write wrong");

   property p_load;
      @(posedge mclk) disable iff (!resetn)
      load_apply |=> (dac_code[15:0] == $past(next_dac0));
   endproperty
   a_load: assert property (p_load) else $error("load used wrong register");
endmodule // dax_aux_ctrl

/* testbench/dax_host.sv */
// Host model issuing command words to the auxiliary control logic
`timescale 1ns/10ps
module dax_host (
   // Clock
   input wire logic mclk,
   // Command word
   output logic cmd_valid,
   output logic [1:0] cmd_mode,
   output logic [5:0] cmd_addr,
   output logic [15:0] cmd_data
);
   // Code that selects the general-purpose pin register
   localparam logic [5:0] GPIO_CODE = 6'b001101;

   initial begin
      cmd_valid = 1'b0;
      cmd_mode = 2'h0;
      cmd_addr = 6'h00;
      cmd_data = 16'h0000;
   end

   // One word per call; released fields show inverted stale values
   task automatic send(input logic [1:0] m, input logic [5:0] a, input logic [15:0] d);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_mode <= m;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_mode <= ~m;
      cmd_addr <= ~a;
      cmd_data <= ~d;
   endtask

   task automatic set_gpio(input logic [1:0] v);
      send(2'h0, GPIO_CODE, {14'h0000, v});
   endtask
endmodule // dax_host

/* testbench/tb_top.sv */
// Self-checking testbench for the DAC auxiliary control logic
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [1:0] m;
      logic [5:0] a;
      logic [15:0] d;
      logic [8:0] e;
   } dax_row_s;
   logic mclk, resetn, cmd_valid, rd_valid, data_format_select, load_strobe_n;
   logic over_temp, busy_n, gpio_i, gpio_o, gpio_oe, monitor_output_oe;
   logic monitor_source_type, channel_to_ground;
   logic [1:0] cmd_mode;
   logic [5:0] cmd_addr;
   logic [15:0] cmd_data, rd_data;
   logic [3:0] monitor_channel_sel;
   logic [255:0] dac_code;
   int fail_count = 0;
   int comparisons = 0;
   dax_row_s rows [9];

   dax_host dax_host_i (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data));
   dax_aux_ctrl dax_aux_ctrl_i (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_mode(cmd_mode), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .data_format_select(data_format_select),
      .load_strobe_n(load_strobe_n), .over_temp(over_temp), .busy_n(busy_n),
      .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
      .monitor_output_oe(monitor_output_oe), .monitor_source_type(monitor_source_type),
      .monitor_channel_sel(monitor_channel_sel), .channel_to_ground(channel_to_ground),
      .dac_code(dac_code));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Readback strobe stands only in the cycle after its taking edge; data holds until the next read
   task automatic rdchk(input logic [5:0] code, input logic [15:0] exp);
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_READBACK, {10'h000, code});
      #1;
      chk({15'h0000, rd_valid}, 16'h0001, "read strobe");
      chk(rd_data, exp, "read data");
   endtask

   task automatic load();
      @(posedge mclk);
      load_strobe_n <= 1'b0;
      repeat (2) @(posedge mclk);
      load_strobe_n <= 1'b1;
      cyc(8);
   endtask

   function automatic logic [15:0] word(input int ch);
      return dac_code[ch*16 +: 16];
   endfunction

   initial begin
      #100us;
      fail_count++;
      end_sim();
   end

   initial begin
      resetn = 1'b0;
      data_format_select = 1'b0;
      load_strobe_n = 1'b1;
      over_temp = 1'b0;
      gpio_i = 1'b0;
      rows[0] = '{2'h0, dax_pkg::SF_GPIO, 16'h0003, 9'b110000000};
      rows[1] = '{2'h0, dax_pkg::SF_GPIO, 16'h0002, 9'b100000000};
      rows[2] = '{2'h0, dax_pkg::SF_GPIO, 16'h0001, 9'b000000000};
      rows[3] = '{2'h0, dax_pkg::SF_MONITOR, 16'h002a, 9'b001010100};
      rows[4] = '{2'h0, dax_pkg::SF_MONITOR, 16'h000a, 9'b000010100};
      rows[5] = '{2'h0, dax_pkg::SF_MONITOR, 16'h0031, 9'b001100010};
      rows[6] = '{2'h0, dax_pkg::SF_CONTROL, 16'h0001, 9'b001100011};
      rows[7] = '{2'h0, dax_pkg::SF_CONTROL, 16'h0000, 9'b001100010};
      rows[8] = '{2'h0, dax_pkg::SF_GPIO, 16'h0000, 9'b001100010};
      cyc(8);
      chk({gpio_oe, monitor_output_oe, channel_to_ground, busy_n}, 16'h0001, "reset");
      chk(word(7), 16'h8000, "reset code");
      @(posedge mclk);
      resetn <= 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         dax_host_i.send(rows[i].m, rows[i].a, rows[i].d);
         cyc(2);
         chk({gpio_oe, gpio_o, monitor_output_oe, monitor_source_type, monitor_channel_sel,
            channel_to_ground}, rows[i].e, "config");
      end
      $display("test config rows done");
      dax_host_i.set_gpio(2'h0);
      gpio_i <= 1'b1;
      cyc(6);
      rdchk(dax_pkg::SF_GPIO, 16'h0001);
      @(posedge mclk) gpio_i <= 1'b0;
      cyc(6);
      rdchk(dax_pkg::SF_GPIO, 16'h0000);
      $display("test gpio readback done");
      dax_host_i.send(dax_pkg::MODE_LEVEL, 6'h03, 16'h1234);
      load();
      chk(word(3), 16'h1234, "binary level");
      @(posedge mclk) data_format_select <= 1'b1;
      cyc(6);
      dax_host_i.send(dax_pkg::MODE_LEVEL, 6'h03, 16'h1234);
      dax_host_i.send(dax_pkg::MODE_GAIN, 6'h05, 16'h7fff);
      dax_host_i.send(dax_pkg::MODE_LEVEL, 6'h05, 16'h1000);
      dax_host_i.send(dax_pkg::MODE_OFFSET, 6'h06, 16'h1000);
      load();
      chk(word(3), 16'h9234, "twos level");
      chk(word(5), 16'h4800, "gain binary");
      chk(word(6), 16'h9000, "twos offset");
      @(posedge mclk) data_format_select <= 1'b0;
      cyc(6);
      $display("test data format done");
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_CONTROL, 16'h0004);
      dax_host_i.send(dax_pkg::MODE_LEVEL, 6'h00, 16'h2222);
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_CONTROL, 16'h0000);
      dax_host_i.send(dax_pkg::MODE_LEVEL, 6'h00, 16'h1111);
      load();
      chk(word(0), 16'h1111, "level a");
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_AB_SEL0, 16'h0001);
      for (int i = 1; i <= 60; i++) begin
         @(posedge mclk);
         if (i == 5) load_strobe_n <= 1'b0;
         if (i == 8) load_strobe_n <= 1'b1;
         #1;
         if (i == 1 || i == 59) chk({15'h0000, busy_n}, 16'h0000, "busy");
         if (i == 60) chk({15'h0000, busy_n}, 16'h0001, "busy end");
         if (i == 50) chk(word(0), 16'h1111, "load held");
      end
      cyc(1);
      cyc(3);
      chk(word(0), 16'h2222, "level b");
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_AB_SEL1, 16'h00a5);
      rdchk(dax_pkg::SF_AB_SEL1, 16'h00a5);
      $display("test toggle done");
      @(posedge mclk) over_temp <= 1'b1;
      cyc(8);
      chk({15'h0000, channel_to_ground}, 16'h0000, "hot disabled");
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_CONTROL, 16'h0002);
      cyc(3);
      chk({15'h0000, channel_to_ground}, 16'h0001, "hot shutdown");
      rdchk(dax_pkg::SF_CONTROL, 16'h0012);
      @(posedge mclk) over_temp <= 1'b0;
      cyc(8);
      chk({15'h0000, channel_to_ground}, 16'h0001, "cooled");
      chk(word(0), 16'h2222, "kept");
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_CONTROL, 16'h0000);
      cyc(2);
      chk({15'h0000, channel_to_ground}, 16'h0000, "released");
      chk(word(0), 16'h2222, "restored");
      $display("test thermal done");
      dax_host_i.set_gpio(2'h3);
      dax_host_i.send(dax_pkg::MODE_SPECIAL, dax_pkg::SF_CONTROL, 16'h0003);
      @(posedge mclk) resetn <= 1'b0;
      cyc(4);
      chk({gpio_oe, monitor_output_oe, channel_to_ground, busy_n}, 16'h0001, "mid reset");
      @(posedge mclk) resetn <= 1'b1;
      cyc(2);
      chk({gpio_oe, monitor_output_oe, channel_to_ground, busy_n}, 16'h0001, "released");
      rdchk(dax_pkg::SF_CONTROL, 16'h0000);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule // tb_top
